// ---- hdl/rprb_bank.sv ----
module rprb_bank (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Status from neighbouring logic, same clock
	input wire logic tail_pl_scale_ns,
	input wire logic head_ref_active,
	// Decoded settings to the consumers
	output rprb_pkg::rprb_tail_t tail_cfg,
	output rprb_pkg::rprb_head_t head_cfg
);
	import rprb_pkg::*;

	// Reset synchroniser stages
	logic rst_meta_q;
	logic rst_q;
	// Byte storage
	logic [7:0] mem_q [NBYTES];
	// Decode of the current address
	logic hit;
	logic [5:0] hit_idx;
	logic [15:0] rel_addr;
	// Next values of the decoded views
	rprb_tail_t tail_d;
	rprb_head_t head_d;

	// Byte index of an absolute address
	function automatic logic [5:0] idx(input logic [15:0] a);
		logic [15:0] r;
		r = a - ADDR_REF_DIV;
		return r[5:0];
	endfunction

	// Writable bits of each byte; the rest stay zero
	function automatic logic [7:0] wmask(input logic [5:0] i);
		logic [7:0] m;
		m = MASK_FULL;
		if (i == idx(ADDR_REF_DIV + 16'h0003)) begin
			m = MASK_REF_DIV_TOP;
		end else if (i == idx(ADDR_FB_INT + 16'h0002)) begin
			m = MASK_NIBBLE_LO;
		end else if (i == idx(ADDR_FB_INT + 16'h0003)) begin
			m = MASK_NONE;
		end else if (i == idx(ADDR_FRAC + 16'h0001)) begin
			m = MASK_FRAC_MID;
		end else if (i == idx(ADDR_FRAC + 16'h0002)) begin
			m = MASK_FRAC_TOP;
		end else if (i == idx(ADDR_PRIO)) begin
			m = MASK_PRIO;
		end else if (i == idx(ADDR_PERIOD_PAD) || i == idx(ADDR_PERIOD_PAD + 16'h0001)) begin
			// Padding is never stored, so zeros read back whatever arrives
			m = MASK_NONE;
		end else if (i == idx(ADDR_INNER_TOL + 16'h0002)) begin
			m = MASK_NIBBLE_LO;
		end else if (i == idx(ADDR_OUTER_TOL + 16'h0002)) begin
			m = MASK_NIBBLE_LO;
		end
		return m;
	endfunction

	// Stored byte at an absolute address
	function automatic logic [7:0] at(input logic [15:0] a);
		return mem_q[idx(a)];
	endfunction

	// Reset release through two flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_q <= rst_meta_q;
		end
	end

	// Address decode, out-of-range addresses miss
	always_comb begin
		rel_addr = reg_addr - ADDR_REF_DIV;
		hit_idx = rel_addr[5:0];
		hit = (rel_addr < 16'(NBYTES));
	end

	// One storage process per byte
	for (genvar i = 0; i < NBYTES; i++) begin : g_byte
		always_ff @(posedge sys_clk or negedge rst_q) begin
			if (!rst_q) begin
				mem_q[i] <= RST_BYTE;
			end else if (reg_wr && hit && hit_idx == 6'(i)) begin
				// Masked bits drop the write
				mem_q[i] <= reg_wdata & wmask(6'(i));
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_q) begin
		if (!rst_q) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && hit) begin
			reg_rdata <= mem_q[hit_idx];
		end else begin
			// Unmapped reads and idle cycles give zero
			reg_rdata <= 8'h00;
		end
	end

	// Decode of the first profile's tail
	always_comb begin
		logic [29:0] r_raw;
		logic [19:0] s_raw;
		logic [15:0] pl_raw;
		r_raw = {mem_q[idx(ADDR_REF_DIV + 16'h0003)][5:0], at(ADDR_REF_DIV + 16'h0002),
			at(ADDR_REF_DIV + 16'h0001), at(ADDR_REF_DIV)};
		s_raw = {mem_q[idx(ADDR_FB_INT + 16'h0002)][3:0], at(ADDR_FB_INT + 16'h0001),
			at(ADDR_FB_INT)};
		pl_raw = {at(ADDR_PL_THR + 16'h0001), at(ADDR_PL_THR)};
		tail_d.ref_div_ratio = {1'b0, r_raw} + 31'h00000001;
		tail_d.fb_div_ratio = {1'b0, s_raw} + 21'h000001;
		// Flag only; the divider still runs with what was written
		tail_d.fb_below_min = (s_raw < FB_DIV_MIN);
		// Split fraction fields
		tail_d.frac_v = {mem_q[idx(ADDR_FRAC + 16'h0001)][1:0], at(ADDR_FRAC)};
		tail_d.frac_u = {mem_q[idx(ADDR_FRAC + 16'h0002)][5:0],
			mem_q[idx(ADDR_FRAC + 16'h0001)][7:4]};
		// The first profile's priorities byte lies outside this bank, so its
		// scale bit arrives on a port from the neighbouring bank
		// Scale bit is the port tail_pl_scale_ns, not the second profile's priorities byte at ADDR_PRIO
		if (tail_pl_scale_ns) begin
			tail_d.pl_thr_ps = 26'(pl_raw) * PS_PER_NS;
		end else begin
			tail_d.pl_thr_ps = 26'(pl_raw);
		end
		tail_d.pl_fill = at(ADDR_PL_FILL);
		tail_d.pl_drain = at(ADDR_PL_DRAIN);
		tail_d.fl_thr_ps = {at(ADDR_FL_THR + 16'h0002), at(ADDR_FL_THR + 16'h0001),
			at(ADDR_FL_THR)};
		tail_d.fl_fill = at(ADDR_FL_FILL);
		tail_d.fl_drain = at(ADDR_FL_DRAIN);
	end

	// Decode of the second profile's head
	always_comb begin
		logic [7:0] pr;
		pr = at(ADDR_PRIO);
		head_d.pl_scale_ns = pr[PRIO_SCALE_BIT];
		head_d.sel_prio = pr[PRIO_SEL_LSB +: 3];
		head_d.prom_prio = pr[PRIO_PROM_LSB +: 3];
		// Active reference ranks by its promoted level
		head_d.eff_prio = head_ref_active ? pr[PRIO_PROM_LSB +: 3] : pr[PRIO_SEL_LSB +: 3];
		// Misprogramming is reported, not corrected
		head_d.prio_order_bad = (pr[PRIO_PROM_LSB +: 3] > pr[PRIO_SEL_LSB +: 3]);
		head_d.ref_period_fs = {at(ADDR_PERIOD + 16'h0004), at(ADDR_PERIOD + 16'h0003),
			at(ADDR_PERIOD + 16'h0002), at(ADDR_PERIOD + 16'h0001), at(ADDR_PERIOD)};
		head_d.inner_tol = {mem_q[idx(ADDR_INNER_TOL + 16'h0002)][3:0],
			at(ADDR_INNER_TOL + 16'h0001), at(ADDR_INNER_TOL)};
		head_d.outer_tol = {mem_q[idx(ADDR_OUTER_TOL + 16'h0002)][3:0],
			at(ADDR_OUTER_TOL + 16'h0001), at(ADDR_OUTER_TOL)};
		head_d.valid_ms = {at(ADDR_VALID_TMR + 16'h0001), at(ADDR_VALID_TMR)};
		head_d.redet_ms = {at(ADDR_REDET_TMR + 16'h0001), at(ADDR_REDET_TMR)};
	end

	// Registered outputs, one cycle behind storage
	always_ff @(posedge sys_clk or negedge rst_q) begin
		if (!rst_q) begin
			tail_cfg <= '0;
			head_cfg <= '0;
		end else begin
			tail_cfg <= tail_d;
			head_cfg <= head_d;
		end
	end

	// Divider ratios follow the stored bytes
	AST_REF_DIV: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> tail_cfg.ref_div_ratio ==
		{1'b0, $past(mem_q[3][5:0]), $past(mem_q[2]), $past(mem_q[1]), $past(mem_q[0])}
		+ 31'h00000001)
		else $error("reference divide ratio is not stored value plus one");

	// Feedback ratio carries one extra bit so the plus one never wraps
	AST_FB_DIV: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> tail_cfg.fb_div_ratio ==
		{1'b0, $past(mem_q[6][3:0]), $past(mem_q[5]), $past(mem_q[4])} + 21'h000001)
		else $error("feedback divide ratio is not stored value plus one");

	// Nanosecond mode multiplies the raw threshold by the ps-per-ns factor
	AST_PL_SCALE: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) && $past(tail_pl_scale_ns) |->
		tail_cfg.pl_thr_ps == 26'({$past(mem_q[12]), $past(mem_q[11])}) * PS_PER_NS)
		else $error("phase threshold not scaled to nanoseconds");

	// Second profile takes its scale bit from its own priorities byte
	AST_HEAD_SCALE: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.pl_scale_ns == $past(mem_q[20][7]))
		else $error("scale bit not taken from priorities byte");

	// Active status one edge back picks which field ranks the reference
	AST_EFF_PRIO: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.eff_prio ==
		($past(head_ref_active) ? head_cfg.prom_prio : head_cfg.sel_prio))
		else $error("effective priority wrong for active state");

	// Period ends: lowest address is the least significant byte
	AST_PERIOD: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.ref_period_fs[7:0] == $past(mem_q[21])
		&& head_cfg.ref_period_fs[39:32] == $past(mem_q[25]))
		else $error("reference period byte order wrong");

	// High bytes of both timers sit at the higher address
	AST_TIMERS: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.valid_ms[15:8] == $past(mem_q[35])
		&& head_cfg.redet_ms[15:8] == $past(mem_q[37]))
		else $error("timer high byte not from higher address");

	// Fraction fields are spread over split nibbles and bit pairs
	AST_FRAC: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> tail_cfg.frac_u == {$past(mem_q[10][5:0]), $past(mem_q[9][7:4])}
		&& tail_cfg.frac_v[9:8] == $past(mem_q[9][1:0]))
		else $error("fraction fields assembled wrongly");

	// The fully unused divider byte never stores; write and read are watched
	// apart so that a read of some other byte is never taken for this one
	AST_UNUSED: assert property (@(posedge sys_clk) disable iff (!rst_q)
		reg_wr && hit && hit_idx == 6'h07 |=> mem_q[7] == 8'h00)
		else $error("unused byte stored a write");

	AST_UNUSED_RD: assert property (@(posedge sys_clk) disable iff (!rst_q)
		reg_rd && hit && hit_idx == 6'h07 |=> reg_rdata == 8'h00)
		else $error("unused byte read back nonzero");

	// Read data stands for one cycle only, then falls back to zero
	AST_RDATA: assert property (@(posedge sys_clk) disable iff (!rst_q)
		!$past(reg_rd) && $past(rst_q) |-> reg_rdata == 8'h00)
		else $error("read data present outside the read answer cycle");

	// Outer tolerance top nibble from the low half of its third byte
	AST_TOL: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.outer_tol[19:16] == $past(mem_q[33][3:0]))
		else $error("outer tolerance top nibble misplaced");

	// Read port: the answer is the stored byte as it stood at the strobe edge
	AST_RD_BYTE: assert property (@(posedge sys_clk) disable iff (!rst_q)
		reg_rd && hit |=> reg_rdata == $past(mem_q[hit_idx]))
		else $error("read answer differs from stored byte");

	// Addresses outside the bank answer zero, so a stray read is harmless
	AST_RD_MISS: assert property (@(posedge sys_clk) disable iff (!rst_q)
		reg_rd && !hit |=> reg_rdata == 8'h00)
		else $error("unmapped read answered nonzero");

	// A write lands at once with only its writable bits
	AST_WR_LANDS: assert property (@(posedge sys_clk) disable iff (!rst_q)
		reg_wr && hit |=> mem_q[$past(hit_idx)] == ($past(reg_wdata) & wmask($past(hit_idx))))
		else $error("write did not land with its writable bits");

	// Partial bytes never hold a bit outside their mask, whatever software sends
	AST_MASKS: assert property (@(posedge sys_clk) disable iff (!rst_q)
		(mem_q[3] & ~MASK_REF_DIV_TOP) == 8'h00 && (mem_q[6] & ~MASK_NIBBLE_LO) == 8'h00
		&& (mem_q[9] & ~MASK_FRAC_MID) == 8'h00 && (mem_q[10] & ~MASK_FRAC_TOP) == 8'h00
		&& (mem_q[20] & ~MASK_PRIO) == 8'h00 && (mem_q[30] & ~MASK_NIBBLE_LO) == 8'h00
		&& (mem_q[33] & ~MASK_NIBBLE_LO) == 8'h00)
		else $error("unused bit held in a partial byte");

	// Padding after the period is never stored, so it always reads as zeros
	AST_PAD: assert property (@(posedge sys_clk) disable iff (!rst_q)
		mem_q[26] == 8'h00 && mem_q[27] == 8'h00)
		else $error("period padding holds a value");

	// Picosecond mode passes the raw threshold through unscaled
	AST_PL_PS: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) && !$past(tail_pl_scale_ns) |->
		tail_cfg.pl_thr_ps == 26'({$past(mem_q[12]), $past(mem_q[11])}))
		else $error("phase threshold scaled in picosecond mode");

	// Both priority fields come straight from the priorities byte
	AST_SEL_PRIO: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.sel_prio == $past(mem_q[20][2:0]))
		else $error("selection priority not from its field");

	AST_PROM_PRIO: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.prom_prio == $past(mem_q[20][5:3]))
		else $error("promoted priority not from its field");

	// Effective rank against the raw byte, independent of the decoded fields
	AST_PROM_ACTIVE: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) && $past(head_ref_active) |-> head_cfg.eff_prio == $past(mem_q[20][5:3]))
		else $error("active reference not ranked by promoted priority");

	AST_SEL_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) && !$past(head_ref_active) |-> head_cfg.eff_prio == $past(mem_q[20][2:0]))
		else $error("idle reference not ranked by selection priority");

	// Order flag only reports; the stored fields stay as written
	AST_PRIO_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.prio_order_bad == (head_cfg.prom_prio > head_cfg.sel_prio))
		else $error("priority order flag wrong");

	// Stored value below the minimum is a ratio below the minimum plus one
	AST_FB_MIN: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> tail_cfg.fb_below_min ==
		(tail_cfg.fb_div_ratio < {1'b0, FB_DIV_MIN} + 21'h000001))
		else $error("feedback minimum flag wrong");

	// The extra bit of each ratio keeps an all-ones field from wrapping to zero
	AST_RATIO_NZ: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> tail_cfg.ref_div_ratio != 31'h00000000
		&& tail_cfg.fb_div_ratio != 21'h000000)
		else $error("divide ratio wrapped to zero");

	// Lock detector fields, lowest address as least significant byte
	AST_FL_THR: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> tail_cfg.fl_thr_ps ==
		{$past(mem_q[17]), $past(mem_q[16]), $past(mem_q[15])})
		else $error("frequency threshold byte order wrong");

	AST_PL_RATES: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> tail_cfg.pl_fill == $past(mem_q[13])
		&& tail_cfg.pl_drain == $past(mem_q[14]))
		else $error("phase detector rates swapped or lost");

	AST_FL_RATES: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> tail_cfg.fl_fill == $past(mem_q[18])
		&& tail_cfg.fl_drain == $past(mem_q[19]))
		else $error("frequency detector rates swapped or lost");

	// Middle bytes of the period, between the two ends checked above
	AST_PERIOD_MID: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.ref_period_fs[31:8] ==
		{$past(mem_q[24]), $past(mem_q[23]), $past(mem_q[22])})
		else $error("reference period middle bytes wrong");

	AST_TIMERS_LO: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.valid_ms[7:0] == $past(mem_q[34])
		&& head_cfg.redet_ms[7:0] == $past(mem_q[36]))
		else $error("timer low byte not from lower address");

	// Tolerances: the top nibble of each sits in the low half of its third byte
	AST_INNER_TOL: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.inner_tol ==
		{$past(mem_q[30][3:0]), $past(mem_q[29]), $past(mem_q[28])})
		else $error("inner tolerance assembled wrongly");

	AST_OUTER_LO: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> head_cfg.outer_tol[15:0] == {$past(mem_q[32]), $past(mem_q[31])})
		else $error("outer tolerance low bytes wrong");

	// Low byte of the second fraction field
	AST_FRAC_V_LO: assert property (@(posedge sys_clk) disable iff (!rst_q)
		$past(rst_q) |-> tail_cfg.frac_v[7:0] == $past(mem_q[8]))
		else $error("fraction low byte wrong");

endmodule

// ---- include/rprb_pkg.sv ----
package rprb_pkg;

	// Byte addresses of the bank (tail of one profile, head of the next)
	localparam logic [15:0] ADDR_REF_DIV = 16'h069E;
	localparam logic [15:0] ADDR_FB_INT = 16'h06A2;
	localparam logic [15:0] ADDR_FRAC = 16'h06A6;
	localparam logic [15:0] ADDR_PL_THR = 16'h06A9;
	localparam logic [15:0] ADDR_PL_FILL = 16'h06AB;
	localparam logic [15:0] ADDR_PL_DRAIN = 16'h06AC;
	localparam logic [15:0] ADDR_FL_THR = 16'h06AD;
	localparam logic [15:0] ADDR_FL_FILL = 16'h06B0;
	localparam logic [15:0] ADDR_FL_DRAIN = 16'h06B1;
	localparam logic [15:0] ADDR_PRIO = 16'h06B2;
	localparam logic [15:0] ADDR_PERIOD = 16'h06B3;
	localparam logic [15:0] ADDR_PERIOD_PAD = 16'h06B8;
	localparam logic [15:0] ADDR_INNER_TOL = 16'h06BA;
	localparam logic [15:0] ADDR_OUTER_TOL = 16'h06BD;
	localparam logic [15:0] ADDR_VALID_TMR = 16'h06C0;
	localparam logic [15:0] ADDR_REDET_TMR = 16'h06C2;
	localparam int NBYTES = 38;

	// Writable-bit masks of the partial bytes
	localparam logic [7:0] MASK_FULL = 8'hFF;
	localparam logic [7:0] MASK_NONE = 8'h00;
	localparam logic [7:0] MASK_REF_DIV_TOP = 8'h3F;
	localparam logic [7:0] MASK_NIBBLE_LO = 8'h0F;
	localparam logic [7:0] MASK_FRAC_MID = 8'hF3;
	localparam logic [7:0] MASK_FRAC_TOP = 8'h3F;
	localparam logic [7:0] MASK_PRIO = 8'hBF;

	// Field positions inside the priorities byte
	localparam int PRIO_SCALE_BIT = 7;
	localparam int PRIO_PROM_LSB = 3;
	localparam int PRIO_SEL_LSB = 0;

	// Reset value of every stored byte
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Numbers used by the consumers
	localparam logic [25:0] PS_PER_NS = 26'h00003E8;
	localparam logic [19:0] FB_DIV_MIN = 20'h00007;

	// Decoded view of the first profile's tail
	typedef struct packed {
		logic [30:0] ref_div_ratio;
		logic [20:0] fb_div_ratio;
		logic fb_below_min;
		logic [9:0] frac_u;
		logic [9:0] frac_v;
		logic [25:0] pl_thr_ps;
		logic [7:0] pl_fill;
		logic [7:0] pl_drain;
		logic [23:0] fl_thr_ps;
		logic [7:0] fl_fill;
		logic [7:0] fl_drain;
	} rprb_tail_t;

	// Decoded view of the second profile's head
	typedef struct packed {
		logic pl_scale_ns;
		logic [2:0] sel_prio;
		logic [2:0] prom_prio;
		logic [2:0] eff_prio;
		logic prio_order_bad;
		logic [39:0] ref_period_fs;
		logic [19:0] inner_tol;
		logic [19:0] outer_tol;
		logic [15:0] valid_ms;
		logic [15:0] redet_ms;
	} rprb_head_t;

endpackage

// ---- test/rprb_tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rprb_pkg::*;

	// Clock, reset and design inputs, all defined at time zero
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic tail_pl_scale_ns = 1'b0;
	logic head_ref_active = 1'b0;
	logic [7:0] reg_rdata;
	rprb_tail_t tail_cfg;
	rprb_head_t head_cfg;

	// Bank model: one byte per address, plus pending read answers
	logic [7:0] mem [NBYTES];
	logic [7:0] rd_q [$];
	logic [7:0] rd_exp;
	logic took_rd = 1'b0;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	int i;
	int k;
	logic [15:0] a;
	// Boundary feedback values and priority bytes, bit 6 set on purpose in all but 8'h12
	logic [7:0] sv [4] = '{8'h06, 8'h07, 8'h00, 8'hFF};
	logic [7:0] pv [4] = '{8'hDA, 8'h12, 8'h7F, 8'hC0};

	rprb_bank dut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.tail_pl_scale_ns(tail_pl_scale_ns),
		.head_ref_active(head_ref_active),
		.tail_cfg(tail_cfg),
		.head_cfg(head_cfg)
	);

	// 10 MHz clock
	always #50 sys_clk = ~sys_clk;

	// Writable bits per byte; unused bits never stick
	function automatic logic [7:0] msk(input int n);
		case (n)
			3, 10: msk = 8'h3F;
			6, 30, 33: msk = 8'h0F;
			7, 26, 27: msk = 8'h00;
			9: msk = 8'hF3;
			20: msk = 8'hBF;
			default: msk = 8'hFF;
		endcase
	endfunction

	task automatic cmp(input logic [159:0] got, input logic [159:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One-cycle strobes; each task owns exactly one edge, so calls chain without gaps
	task automatic wr(input logic [15:0] ad, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= ad;
		// Software only ever sends zeros to the period padding
		if (ad == ADDR_PERIOD_PAD || ad == ADDR_PERIOD_PAD + 16'h0001)
			reg_wdata <= 8'h00;
		else
			reg_wdata <= d;
		if (ad >= ADDR_REF_DIV && ad < ADDR_REF_DIV + 16'h0026)
			mem[ad - ADDR_REF_DIV] = d & msk(int'(ad - ADDR_REF_DIV));
	endtask

	task automatic rd(input logic [15:0] ad);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= ad;
		// Unmapped places answer zero
		if (ad >= ADDR_REF_DIV && ad < ADDR_REF_DIV + 16'h0026)
			rd_q.push_back(mem[ad - ADDR_REF_DIV]);
		else
			rd_q.push_back(8'h00);
	endtask

	task automatic idle();
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask

	// Let the last write and status change reach the decoded outputs, then compare
	task automatic chk();
		rprb_tail_t t;
		rprb_head_t h;
		logic [19:0] s;
		logic [25:0] p;
		repeat (3) idle();
		@(negedge sys_clk);
		s = {mem[6][3:0], mem[5], mem[4]};
		p = {10'h000, mem[12], mem[11]};
		t.ref_div_ratio = {1'b0, mem[3][5:0], mem[2], mem[1], mem[0]} + 31'h1;
		t.fb_div_ratio = {1'b0, s} + 21'h1;
		t.fb_below_min = (s < 20'h00007);
		t.frac_v = {mem[9][1:0], mem[8]};
		t.frac_u = {mem[10][5:0], mem[9][7:4]};
		t.pl_thr_ps = tail_pl_scale_ns ? p * 26'h00003E8 : p;
		t.pl_fill = mem[13];
		t.pl_drain = mem[14];
		t.fl_thr_ps = {mem[17], mem[16], mem[15]};
		t.fl_fill = mem[18];
		t.fl_drain = mem[19];
		h.pl_scale_ns = mem[20][7];
		h.sel_prio = mem[20][2:0];
		h.prom_prio = mem[20][5:3];
		h.eff_prio = head_ref_active ? h.prom_prio : h.sel_prio;
		h.prio_order_bad = (h.prom_prio > h.sel_prio);
		h.ref_period_fs = {mem[25], mem[24], mem[23], mem[22], mem[21]};
		h.inner_tol = {mem[30][3:0], mem[29], mem[28]};
		h.outer_tol = {mem[33][3:0], mem[32], mem[31]};
		h.valid_ms = {mem[35], mem[34]};
		h.redet_ms = {mem[37], mem[36]};
		cmp(160'(tail_cfg), 160'(t));
		cmp(160'(head_cfg), 160'(h));
	endtask

	// Read answer stands one cycle after the strobe edge, zero otherwise
	always @(posedge sys_clk)
		took_rd <= reg_rd;
	always @(negedge sys_clk) begin
		rd_exp = took_rd ? rd_q.pop_front() : 8'h00;
		cmp(160'(reg_rdata), 160'(rd_exp));
	end

	// Hang guard, far above the fewer than a thousand cycles the sequence needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		void'($urandom(93));
		foreach (mem[n]) mem[n] = RST_BYTE;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) idle();
		// Reset contents, including both unmapped neighbours
		for (i = -2; i < 40; i++) rd(ADDR_REF_DIV + 16'(i));
		chk();
		// All ones: partial bytes and padding keep only their writable bits
		for (i = 0; i < 38; i++) wr(ADDR_REF_DIV + 16'(i), 8'hFF);
		for (i = -2; i < 40; i++) rd(ADDR_REF_DIV + 16'(i));
		chk();
		// Feedback minimum and priority order boundaries, both status levels
		wr(ADDR_FB_INT + 16'h0001, 8'h00);
		wr(ADDR_FB_INT + 16'h0002, 8'h00);
		for (k = 0; k < 4; k++) begin
			wr(ADDR_FB_INT, sv[k]);
			wr(ADDR_PRIO, pv[k]);
			@(posedge sys_clk);
			tail_pl_scale_ns <= k[0];
			head_ref_active <= k[1];
			reg_wr <= 1'b0;
			chk();
		end
		// Random traffic, back to back, with unmapped places and status changes
		repeat (40) begin
			repeat (10) begin
				a = 16'h069C + 16'($urandom_range(0, 41));
				if ($urandom_range(0, 1) == 1)
					wr(a, 8'($urandom));
				else
					rd(a);
			end
			@(posedge sys_clk);
			tail_pl_scale_ns <= 1'($urandom);
			head_ref_active <= 1'($urandom);
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
			chk();
		end
		// Reset in mid-run clears every byte
		idle();
		rst_n <= 1'b0;
		repeat (6) idle();
		rst_n <= 1'b1;
		foreach (mem[n]) mem[n] = RST_BYTE;
		repeat (3) idle();
		for (i = 0; i < 38; i++) rd(ADDR_REF_DIV + 16'(i));
		chk();
		give_verdict();
	end
endmodule
